// *** logic/mic_pkg.sv ***
// Package of constants and types for the interrupt controller
package mic_pkg;
  // Register indices; the byte address is four times the index
  localparam logic [7:0] MIC_IDX_IRQ_CONTROL   = 8'h0b;
  localparam logic [7:0] MIC_IDX_PERIPH_FLAGS  = 8'h0c;
  localparam logic [7:0] MIC_IDX_PERIPH_ENA    = 8'h8c;
  localparam logic [7:0] MIC_IDX_OPTION        = 8'h81;
  localparam logic [7:0] MIC_IDX_CORE_STATUS   = 8'h90;
  localparam logic [9:0] MIC_ADDR_IRQ_CONTROL  = {MIC_IDX_IRQ_CONTROL, 2'b00};
  localparam logic [9:0] MIC_ADDR_PERIPH_FLAGS = {MIC_IDX_PERIPH_FLAGS, 2'b00};
  localparam logic [9:0] MIC_ADDR_PERIPH_ENA   = {MIC_IDX_PERIPH_ENA, 2'b00};
  localparam logic [9:0] MIC_ADDR_OPTION       = {MIC_IDX_OPTION, 2'b00};
  localparam logic [9:0] MIC_ADDR_CORE_STATUS  = {MIC_IDX_CORE_STATUS, 2'b00};
  // Field positions of the control register, the peripheral registers (CMP) and the option register (EDGE)
  localparam int MIC_BIT_GLOBAL_EN = 7;
  localparam int MIC_BIT_PERIPH_EN = 6;
  localparam int MIC_BIT_TIE   = 5;
  localparam int MIC_BIT_EIE   = 4;
  localparam int MIC_BIT_PCIE  = 3;
  localparam int MIC_BIT_TOF   = 2;
  localparam int MIC_BIT_EF    = 1;
  localparam int MIC_BIT_PCF   = 0;
  localparam int MIC_BIT_CMP   = 6;
  localparam int MIC_BIT_EDGE  = 6;
  // Reset values and the fixed vector
  localparam logic [7:0] MIC_RST_IRQ_CONTROL = 8'h00;
  localparam logic [7:0] MIC_RST_PERIPH      = 8'h00;
  localparam logic [7:0] MIC_RST_OPTION      = 8'hff;
  localparam logic [12:0] MIC_VECTOR         = 13'h0004;
  // Latency in instruction cycles and quarter phases per cycle
  localparam int MIC_SYNC_LATENCY_TCY = 3;
  localparam logic [1:0] MIC_PHASE_Q1 = 2'h0;
  localparam logic [1:0] MIC_PHASE_Q4 = 2'h3;
  localparam logic [1:0] MIC_LAT_CNT  = 2'(MIC_SYNC_LATENCY_TCY - 1);

  // Raw events arriving from the sources during one clock
  typedef struct packed {
    logic       timer_rollover;
    logic       comparator_event;
    logic [3:0] upper_port_pins;
    logic       external_irq_pin;
  } mic_src_t;

  // Core handshake strobes
  typedef struct packed {
    logic       return_from_interrupt;
    logic       global_en_clear;
    logic       sleeping;
    logic       port_read_q2;
  } mic_core_t;

  typedef enum logic [1:0] {MIC_IDLE, MIC_WAIT, MIC_NOP} mic_state_t;
endpackage : mic_pkg

// *** logic/mic_edge_detect.sv ***
// Edge and change detector for one group of synchronous pins
`timescale 1ns/1ps
module mic_edge_detect #(
  parameter int WIDTH = 1
) (
  input  wire logic             mclk,
  input  wire logic             nrst,
  input  wire logic             ce,
  input  wire logic [WIDTH-1:0] pins,
  output logic      [WIDTH-1:0] rise,
  output logic      [WIDTH-1:0] fall
);
  logic [WIDTH-1:0] last_q;
  logic             primed_q;

  // Previous sample; the first enabled clock after reset only primes it,
  // so a pin that idles high does not look like an edge at release
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      last_q   <= '0;
      primed_q <= 1'b0;
    end else if (ce) begin
      last_q   <= pins;
      primed_q <= 1'b1;
    end
  end

  assign rise = {WIDTH{primed_q}} & pins & ~last_q;
  assign fall = {WIDTH{primed_q}} & ~pins & last_q;
endmodule : mic_edge_detect

// *** logic/mic_irq_ctrl.sv ***
// Interrupt controller with APB register slave and vector request to the core
//
// Implementation choice: the APB slave port.
`timescale 1ns/1ps
module mic_irq_ctrl
  import mic_pkg::*;
#(
  parameter int ADDR_W = 10
) (
  input  wire logic              mclk,
  input  wire logic              nrst,
  input  wire logic              ce,
  // APB slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  input  wire logic [3:0]        pstrb,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // Sources and core strobes
  input  wire logic [1:0]        q_phase,
  input  wire mic_src_t          src,
  input  wire mic_core_t         core,
  // Requests to the core
  output logic                   irq_request,
  output logic                   vector_load,
  output logic                   stack_push,
  output logic [12:0]            vector_addr,
  output logic                   wake_up,
  output logic                   nop_insert
);
  logic [7:0]  ctrl_q;
  logic [7:0]  pflag_q;
  logic [7:0]  pena_q;
  logic [7:0]  option_q;
  logic        ext_pend_q;
  logic [1:0]  lat_q;
  logic        vload_q;
  logic        nop_q;
  logic        wake_q;
  logic [12:0] vaddr_q;
  mic_state_t  state_q;

  logic [3:0]  port_rise;
  logic [3:0]  port_fall;
  logic        pin_rise;
  logic        pin_fall;
  logic        pin_edge;
  logic        port_evt;
  logic        apb_wr;
  logic        apb_rd;
  logic        hit;
  logic        wr_ctrl;
  logic        wr_pflag;
  logic        wr_pena;
  logic        wr_opt;
  logic        any_enabled;
  logic        req_raw;
  logic        accept;
  logic [31:0] rdata_d;

  // pin and port detectors
  // One detector module serves the pin and the port group
  mic_edge_detect #(.WIDTH(1)) u_pin_det (
    .mclk (mclk),
    .nrst (nrst),
    .ce   (ce),
    .pins (src.external_irq_pin),
    .rise (pin_rise),
    .fall (pin_fall)
  );

  mic_edge_detect #(.WIDTH(4)) u_port_det (
    .mclk (mclk),
    .nrst (nrst),
    .ce   (ce),
    .pins (src.upper_port_pins),
    .rise (port_rise),
    .fall (port_fall)
  );

  assign pin_edge = option_q[MIC_BIT_EDGE] ? pin_rise : pin_fall;
  // change coinciding with port read is dropped
  assign port_evt = (|(port_rise | port_fall)) & ~core.port_read_q2;

  // APB decode; zero wait states, one access per transfer
  // pready stays high: every register answers at once, so ce must stay high
  assign apb_wr   = psel & penable & pwrite & pstrb[0];
  assign apb_rd   = psel & penable & ~pwrite;
  assign hit      = (paddr == MIC_ADDR_IRQ_CONTROL) | (paddr == MIC_ADDR_PERIPH_FLAGS) |
                    (paddr == MIC_ADDR_PERIPH_ENA) | (paddr == MIC_ADDR_OPTION) |
                    (paddr == MIC_ADDR_CORE_STATUS);
  assign wr_ctrl  = apb_wr & (paddr == MIC_ADDR_IRQ_CONTROL);
  assign wr_pflag = apb_wr & (paddr == MIC_ADDR_PERIPH_FLAGS);
  assign wr_pena  = apb_wr & (paddr == MIC_ADDR_PERIPH_ENA);
  assign wr_opt   = apb_wr & (paddr == MIC_ADDR_OPTION);
  assign pready   = 1'b1;
  assign pslverr  = psel & penable & ~hit;

  // Edge pending until the next Q4/Q1 window opens the flag
  // An edge in Q2 or Q3 is parked here rather than dropped
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      ext_pend_q <= 1'b0;
    end else if (ce) begin
      // flag may only move in Q4 or Q1
      if ((q_phase == MIC_PHASE_Q4) || (q_phase == MIC_PHASE_Q1)) begin
        ext_pend_q <= 1'b0;
      end else if (pin_edge) begin
        ext_pend_q <= 1'b1;
      end
    end
  end

  // Control register: software writes, hardware sets flags and enable
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      ctrl_q <= MIC_RST_IRQ_CONTROL;
    end else if (ce) begin
      if (wr_ctrl) begin
        ctrl_q <= pwdata[7:0];
      end
      // Hardware entry or clear beats the return strobe on the enable
      // accept clears global enable
      if (accept) begin
        ctrl_q[MIC_BIT_GLOBAL_EN] <= 1'b0;
      end else if (core.global_en_clear) begin
        ctrl_q[MIC_BIT_GLOBAL_EN] <= 1'b0;
      end else if (core.return_from_interrupt) begin
        ctrl_q[MIC_BIT_GLOBAL_EN] <= 1'b1;
      end
      // flags set whatever the enables; set beats clear
      if (((q_phase == MIC_PHASE_Q4) || (q_phase == MIC_PHASE_Q1)) &&
          (pin_edge || ext_pend_q)) begin
        ctrl_q[MIC_BIT_EF] <= 1'b1;
      end
      if (src.timer_rollover) begin
        ctrl_q[MIC_BIT_TOF] <= 1'b1;
      end
      if (port_evt) begin
        ctrl_q[MIC_BIT_PCF] <= 1'b1;
      end
    end
  end

  // Peripheral flag register; only bit 6 implemented
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      pflag_q <= MIC_RST_PERIPH;
    end else if (ce) begin
      // comparator flag, set wins over clear
      if (src.comparator_event) begin
        pflag_q[MIC_BIT_CMP] <= 1'b1;
      end else if (wr_pflag) begin
        pflag_q[MIC_BIT_CMP] <= pwdata[MIC_BIT_CMP];
      end
    end
  end

  // Peripheral enable register; other bits keep their reset value
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      pena_q <= MIC_RST_PERIPH;
    end else if (ce && wr_pena) begin
      pena_q[MIC_BIT_CMP] <= pwdata[MIC_BIT_CMP];
    end
  end

  // Option register holds the edge polarity
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      option_q <= MIC_RST_OPTION;
    end else if (ce && wr_opt) begin
      option_q <= pwdata[7:0];
    end
  end

  // request tree
  // Combinational so a flag set now is seen by the sequencer at the next Q4
  // pin mask, timer mask, port mask, peripheral mask
  assign any_enabled = (ctrl_q[MIC_BIT_EIE] & ctrl_q[MIC_BIT_EF]) |
                       (ctrl_q[MIC_BIT_TIE] & ctrl_q[MIC_BIT_TOF]) |
                       (ctrl_q[MIC_BIT_PCIE] & ctrl_q[MIC_BIT_PCF]) |
                       (ctrl_q[MIC_BIT_PERIPH_EN] & pflag_q[MIC_BIT_CMP] & pena_q[MIC_BIT_CMP]);
  assign req_raw     = ctrl_q[MIC_BIT_GLOBAL_EN] & any_enabled;
  assign irq_request = req_raw;
  // Accept only at an instruction-cycle boundary, never during the NOP
  // an interrupt due in the cycle that clears the enable is ignored
  assign accept      = (state_q == MIC_WAIT) && (lat_q == 2'h0) &&
                       (q_phase == MIC_PHASE_Q4) && req_raw && !core.global_en_clear;

  // Latency sequencer counted in whole instruction cycles
  // Limitation: the count starts at the first Q4 that sees the request,
  // so an event just after a boundary waits up to one cycle longer
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      state_q <= MIC_IDLE;
      lat_q   <= 2'h0;
    end else if (ce) begin
      case (state_q)
        MIC_IDLE: begin
          // enable clear forces one NOP cycle
          // no wait starts while asleep; the next instruction runs first
          if (core.global_en_clear) begin
            state_q <= MIC_NOP;
          end else if (req_raw && !core.sleeping && (q_phase == MIC_PHASE_Q4)) begin
            // fixed count independent of instruction length
            state_q <= MIC_WAIT;
            lat_q   <= MIC_LAT_CNT - 2'h1;
          end
        end
        MIC_WAIT: begin
          if (core.global_en_clear) begin
            // a clear mid-wait still costs its NOP; the flag stays pending
            state_q <= MIC_NOP;
          end else if (!req_raw) begin
            // Request withdrawn: start over at the next boundary
            state_q <= MIC_IDLE;
          end else if (q_phase == MIC_PHASE_Q4) begin
            if (lat_q == 2'h0) begin
              state_q <= MIC_IDLE;
            end else begin
              lat_q <= lat_q - 2'h1;
            end
          end
        end
        MIC_NOP: begin
          // pending flags stay untouched, servicing waits
          if (q_phase == MIC_PHASE_Q4) begin
            state_q <= MIC_IDLE;
          end
        end
        default: begin
          // Unreachable codes fall back to idle
          state_q <= MIC_IDLE;
        end
      endcase
    end
  end

  // vector load with push, return address only
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      vload_q <= 1'b0;
    end else if (ce) begin
      vload_q <= accept;
    end
  end

  // Vector address held after the first entry; one fixed vector, no table
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      vaddr_q <= 13'h0000;
    end else if (ce && accept) begin
      vaddr_q <= MIC_VECTOR;
    end
  end

  // NOP marker, registered so the core sees it in the cycle after the clear
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      nop_q <= 1'b0;
    end else if (ce) begin
      // one NOP after a core global_en_clear strobe; accept and software clears of the enable give none
      nop_q <= (state_q == MIC_NOP) || core.global_en_clear;
    end
  end

  // wake on enabled source regardless of global enable
  // Level output; drops one clock after the flag or its enable is cleared
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      wake_q <= 1'b0;
    end else if (ce) begin
      wake_q <= core.sleeping & any_enabled;
    end
  end

  // Outputs straight from their registers
  assign vector_load = vload_q;
  // after wake the core runs the prefetched instruction, then vectors
  assign stack_push  = vload_q;
  assign vector_addr = vaddr_q;
  assign nop_insert  = nop_q;
  assign wake_up     = wake_q;

  // Read mux; unimplemented bits read zero
  // Core status is read-only: wake, nop, waiting, request
  always_comb begin
    rdata_d = 32'h0000_0000;
    if (paddr == MIC_ADDR_IRQ_CONTROL) begin
      rdata_d[7:0] = ctrl_q;
    end else if (paddr == MIC_ADDR_PERIPH_FLAGS) begin
      rdata_d[MIC_BIT_CMP] = pflag_q[MIC_BIT_CMP];
    end else if (paddr == MIC_ADDR_PERIPH_ENA) begin
      rdata_d[MIC_BIT_CMP] = pena_q[MIC_BIT_CMP];
    end else if (paddr == MIC_ADDR_OPTION) begin
      rdata_d[7:0] = option_q;
    end else if (paddr == MIC_ADDR_CORE_STATUS) begin
      rdata_d[3:0] = {wake_q, nop_q, state_q == MIC_WAIT, req_raw};
    end
  end

  // Read data registered during the setup cycle, valid in access
  // Latching at setup keeps prdata steady through the access edge
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      prdata <= 32'h0000_0000;
    end else if (ce && psel && !penable && !pwrite) begin
      prdata <= rdata_d;
    end
  end
endmodule : mic_irq_ctrl

// *** verification/mic_irq_ctrl_assertions.sv ***
// Port-level timing checker for the interrupt controller
`timescale 1ns/1ps
module mic_irq_ctrl_assertions
  import mic_pkg::*;
#(
  parameter int ADDR_W = 10
) (
  input wire logic              mclk,
  input wire logic              nrst,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0]       pwdata,
  input wire logic [3:0]        pstrb,
  input wire logic              pslverr,
  input wire mic_core_t         core,
  input wire logic              irq_request,
  input wire logic              vector_load,
  input wire logic              stack_push,
  input wire logic [12:0]       vector_addr,
  input wire logic              wake_up,
  input wire logic              nop_insert
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);
  logic [4:0] wait_q;
  // Cycles a request has stood unserved while awake; no saturation needed
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      wait_q <= 5'h00;
    end else begin
      wait_q <= (irq_request && !vector_load && !core.sleeping) ? wait_q + 5'h01 : 5'h00;
    end
  end
  vec_addr_a: assert property (vector_load |-> vector_addr == MIC_VECTOR)
    else $error("vector address wrong on entry");
  push_pair_a: assert property (vector_load == stack_push)
    else $error("stack push not paired with vector load");
  entry_drop_a: assert property (vector_load |-> !irq_request)
    else $error("request still up after entry");
  lat_bound_a: assert property (wait_q <= 5'h14)
    else $error("held request not served in time");
  lat_min_a: assert property (vector_load |-> $past(irq_request, 4))
    else $error("vector came too soon after request");
  nop_follow_a: assert property (core.global_en_clear |=> nop_insert && !irq_request)
    else $error("no nop or request after enable clear");
  global_off_a: assert property (psel && penable && pwrite && pstrb[0] && !pwdata[7]
    && paddr == MIC_ADDR_IRQ_CONTROL && !core.return_from_interrupt |=> !irq_request)
    else $error("request with global enable clear");
  wake_sleep_a: assert property (wake_up |-> $past(core.sleeping))
    else $error("wake while not sleeping");
  cov_vec: cover property (vector_load);
  cov_nop: cover property (nop_insert);
  cov_wake: cover property (wake_up);
  cov_err: cover property (pslverr);
endmodule : mic_irq_ctrl_assertions

// *** verification/mic_core_model.sv ***
// Core-side partner: phase counter, instruction strobes, stack capture
`timescale 1ns/1ps
module mic_core_model
  import mic_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        nrst,
  input  wire logic        vector_load,
  input  wire logic        stack_push,
  input  wire logic [12:0] vector_addr,
  input  wire logic        ret_go,
  input  wire logic        clr_go,
  input  wire logic        sleep_i,
  input  wire logic        rdq_go,
  output logic [1:0]       q_phase,
  output mic_core_t        core,
  output int               pushes,
  output logic [12:0]      last_pc
);
  // Phases advance one per clock, Q1 after reset
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      q_phase <= MIC_PHASE_Q1;
    end else begin
      q_phase <= q_phase + 2'h1;
    end
  end
  // Strobes one clock after the bench asks, like a decode stage
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      core <= '0;
    end else begin
      core <= '{ret_go, clr_go, sleep_i, rdq_go};
    end
  end
  // stack capture
  // A lone push or lone load is penalised so the bench count shows it
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      pushes <= 0;
      last_pc <= 13'h0000;
    end else if (vector_load && stack_push) begin
      pushes <= pushes + 1;
      last_pc <= vector_addr;
    end else if (vector_load || stack_push) begin
      pushes <= pushes + 100;
    end
  end
endmodule : mic_core_model

// *** verification/mic_irq_ctrl_tb.sv ***
// Self-checking bench for the interrupt controller
`timescale 1ns/1ps
module mic_irq_ctrl_tb
  import mic_pkg::*;
;
  logic mclk, nrst, psel, penable, pwrite, pready, pslverr, irq_request;
  logic vector_load, stack_push, wake_up, nop_insert, ret_go, clr_go, sleep_i, rdq_go;
  logic [9:0] paddr;
  logic [31:0] pwdata, prdata, r, e;
  logic [12:0] vector_addr, last_pc;
  logic [1:0] q_phase;
  mic_src_t src;
  mic_core_t core;
  int pushes, checks, fails, m_ctl, m_pf, p;
  mic_irq_ctrl DUT (.mclk, .nrst, .ce(1'b1), .psel, .penable, .pwrite, .paddr, .pwdata,
    .pstrb(4'hf), .prdata, .pready, .pslverr, .q_phase, .src, .core, .irq_request,
    .vector_load, .stack_push, .vector_addr, .wake_up, .nop_insert);
  mic_core_model u_core (.mclk, .nrst, .vector_load, .stack_push, .vector_addr, .ret_go,
    .clr_go, .sleep_i, .rdq_go, .q_phase, .core, .pushes, .last_pc);
  // Free-running 25 MHz clock
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
    checks++;
    if (g !== x) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", n, x, g);
    end
  endtask : chk
  task automatic test_done();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : test_done
  // Setup cycle, then access held until pready is seen high at an edge
  task automatic apb(input logic w, input logic [9:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    r = prdata;
    e = {31'h0, pslverr};
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rd(input string n, input logic [9:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk(n, x, r);
  endtask : rd
  task automatic wc(input int v);
    m_ctl = v;
    apb(1'b1, MIC_ADDR_IRQ_CONTROL, 32'(v));
  endtask : wc
  // One-clock source event on bit b of the source bundle
  task automatic ev(input int b);
    @(posedge mclk);
    src[b] <= 1'b1;
    @(posedge mclk);
    src[b] <= 1'b0;
    repeat (6) @(posedge mclk);
  endtask : ev
  task automatic wv(input int n);
    for (int i = 0; i < 30 && pushes != n; i++) @(posedge mclk);
    chk("pushes", n, pushes);
  endtask : wv
  // Hang guard well beyond the expected few hundred cycles
  initial begin
    repeat (20000) @(posedge mclk);
    fails++;
    test_done();
  end
  initial begin
    {nrst, psel, penable, pwrite, paddr, pwdata, ret_go, clr_go, sleep_i, rdq_go} = '0;
    src = '0;
    void'($urandom(3));
    repeat (2) @(posedge mclk);
    nrst <= 1'b1;
    rd("ctl", MIC_ADDR_IRQ_CONTROL, 32'h0);
    rd("pf", MIC_ADDR_PERIPH_FLAGS, 32'h0);
    rd("pe", MIC_ADDR_PERIPH_ENA, 32'h0);
    rd("opt", MIC_ADDR_OPTION, 32'(MIC_RST_OPTION));
    apb(1'b0, 10'h3fc, 32'h0);
    chk("slverr", 32'h1, e);
    wc($urandom & 32'h78);
    rd("ctl", MIC_ADDR_IRQ_CONTROL, m_ctl);
    ev(6);
    m_ctl |= 4;
    rd("ctl", MIC_ADDR_IRQ_CONTROL, m_ctl);
    src.upper_port_pins <= 4'(($urandom % 15) + 1);
    repeat (6) @(posedge mclk);
    m_ctl |= 1;
    rd("ctl", MIC_ADDR_IRQ_CONTROL, m_ctl);
    // A change landing on the Q2 port read is dropped
    wc(m_ctl & 32'hfe);
    rdq_go <= 1'b1;
    @(posedge mclk);
    rdq_go <= 1'b0;
    src.upper_port_pins <= ~src.upper_port_pins;
    repeat (6) @(posedge mclk);
    rd("ctl", MIC_ADDR_IRQ_CONTROL, m_ctl);
    ev(5);
    m_pf = 32'h40;
    rd("pf", MIC_ADDR_PERIPH_FLAGS, m_pf);
    apb(1'b1, MIC_ADDR_PERIPH_ENA, 32'h40);
    rd("pe", MIC_ADDR_PERIPH_ENA, 32'h40);
    // Wrong edge first, then the selected one, for both polarities
    for (p = 0; p < 2; p++) begin
      apb(1'b1, MIC_ADDR_OPTION, 32'hbf | (p << 6));
      src.external_irq_pin <= p[0];
      repeat (8) @(posedge mclk);
      wc(0);
      src.external_irq_pin <= !p[0];
      repeat (8) @(posedge mclk);
      rd("pin", MIC_ADDR_IRQ_CONTROL, 32'h0);
      src.external_irq_pin <= p[0];
      repeat (8) @(posedge mclk);
      rd("pin", MIC_ADDR_IRQ_CONTROL, 32'h2);
    end
    wc(8'ha0);
    ev(6);
    wv(1);
    chk("pc", MIC_VECTOR, last_pc);
    rd("ctl", MIC_ADDR_IRQ_CONTROL, 32'h24);
    wc(8'h20);
    ret_go <= 1'b1;
    @(posedge mclk);
    ret_go <= 1'b0;
    repeat (4) @(posedge mclk);
    rd("ctl", MIC_ADDR_IRQ_CONTROL, 32'ha0);
    wc(8'h80);
    ev(6);
    repeat (20) @(posedge mclk);
    chk("pushes", 1, pushes);
    wc(8'hc0);
    wv(2);
    wc(8'h40);
    clr_go <= 1'b1;
    @(posedge mclk);
    clr_go <= 1'b0;
    wc(8'hc0);
    wv(3);
    wc(8'h20);
    sleep_i <= 1'b1;
    ev(6);
    chk("wake", 32'h1, {31'h0, wake_up});
    chk("pushes", 3, pushes);
    // Enabled request while asleep: no wait, no vector until awake
    wc(8'ha4);
    repeat (20) @(posedge mclk);
    rd("status", MIC_ADDR_CORE_STATUS, 32'h9);
    chk("pushes", 3, pushes);
    sleep_i <= 1'b0;
    wv(4);
    nrst <= 1'b0;
    repeat (2) @(posedge mclk);
    nrst <= 1'b1;
    rd("ctl", MIC_ADDR_IRQ_CONTROL, 32'h0);
    test_done();
  end
endmodule : mic_irq_ctrl_tb
bind mic_irq_ctrl mic_irq_ctrl_assertions #(.ADDR_W(ADDR_W)) u_chk (.mclk, .nrst, .psel,
  .penable, .pwrite, .paddr, .pwdata, .pstrb, .pslverr, .core, .irq_request, .vector_load,
  .stack_push, .vector_addr, .wake_up, .nop_insert);
